// ---- hdl/ttw_pkg.sv ----
// Package with register map, field layout, taps and types of the tick timers block
package ttw_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] DOG_CTRL_IDX  = 8'h09;
   localparam logic [7:0] BASE_CTRL_IDX = 8'h0A;
   localparam logic [7:0] SLOW_CTRL_IDX = 8'h0B;

   // Shared bit positions of the two interval control registers
   localparam int FLAG_BIT  = 7;
   localparam int IE_BIT    = 6;
   localparam int SEL_HI    = 2;
   localparam int SEL_LO    = 1;
   localparam int CLR_BIT   = 0;
   // Watchdog control layout
   localparam int DOG_SRC_BIT = 7;
   localparam int KEY_HI      = 3;

   localparam logic [3:0] DOG_KEY      = 4'h5;
   localparam logic [3:0] DOG_KEY_READ = 4'hF;

   // Counter widths
   localparam int BASE_W = 21;
   localparam int SLOW_W = 15;

   // Tap = highest counter bit whose carry marks the interval end
   // Slow interval 2^10, 2^13, 2^14, 2^15 subclock cycles
   localparam logic [4:0] SLOW_TAP0 = 5'h09;
   localparam logic [4:0] SLOW_TAP1 = 5'h0C;
   localparam logic [4:0] SLOW_TAP2 = 5'h0D;
   localparam logic [4:0] SLOW_TAP3 = 5'h0E;
   // Base interval 2^13, 2^15, 2^18, 2^22 main cycles at half rate counting
   localparam logic [4:0] BASE_TAP0 = 5'h0B;
   localparam logic [4:0] BASE_TAP1 = 5'h0D;
   localparam logic [4:0] BASE_TAP2 = 5'h10;
   localparam logic [4:0] BASE_TAP3 = 5'h14;
   // Watchdog ticks: 2^22 main cycles or 2^14 subclock cycles
   localparam logic [4:0] DOG_BASE_TAP = 5'h14;
   localparam logic [4:0] DOG_SLOW_TAP = 5'h0D;

   // Watchdog expiry on this count of source ticks since the last clear
   localparam logic [1:0] DOG_EXPIRE_CNT = 2'h2;

   localparam int CLK_HZ = 10000000;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        strb0;
   } ttw_apb_req_t;

   typedef struct packed {
      logic       flag;
      logic       irq_en;
      logic [1:0] sel;
   } ttw_intv_t;

   typedef enum logic [1:0] {
      DOG_FRESH,
      DOG_BARRED,
      DOG_RUNNING
   } ttw_dog_state_t;

endpackage

// ---- hdl/ttw_top.sv ----
// Subclock prescaler, base timer and watchdog with an APB register slave
// Operation
// [RQ1] 15-bit subclock prescaler feeds slow ticks
// [RQ2] Slow flag: write 0 clears, read shows event
// [RQ3] Slow flag and enable raise interrupt request
// [RQ4] Read-modify-write reads both flags as one
// [RQ5] Slow interval select: 2^10,2^13,2^14,2^15 cycles
// [RQ6] Writing 0 to slow clear zeroes prescaler
// [RQ7] Both counter clear bits read as one
// [RQ8] 21-bit base timer at half main clock
// [RQ9] Base flag: write 0 clears, interrupt if enabled
// [RQ10] Base interval select: 2^13,2^15,2^18,2^22 cycles
// [RQ11] Writing 0 to base clear zeroes counter
// [RQ12] Chip reset clears both event flags
// [RQ13] Source bit picks base or prescaler tick
// [RQ14] Software fixes source once, prescaler in submode
// [RQ15] First key write 0101 starts watchdog
// [RQ16] Later key writes 0101 clear watchdog counter
// [RQ17] Only reset stops watchdog; key reads 1111
// [RQ18] Standby or hold clears watchdog counter; only STANDBY_I clears it here, there is no hold input
// [RQ19] Missed clear deadline raises internal chip reset
// [RQ20] Two-bit tick counter, reset on second tick
// [RQ21] Flags stay set until software writes zero
`timescale 1ns/1ns
module ttw_top
   import ttw_pkg::*;
#(
   parameter int P_BASE_W = BASE_W,
   parameter int P_SLOW_W = SLOW_W
) (
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   input  wire logic [3:0]  PSTRB_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        SUB_TICK_I,
   input  wire logic        MAIN_CLK_RUN_I,
   input  wire logic        RMW_READ_I,
   input  wire logic        STANDBY_I,
   output logic             SLOW_IRQ_O,
   output logic             BASE_IRQ_O,
   output logic             WDOG_RST_O
);

   generate
      if (P_BASE_W != 21 || P_SLOW_W != 15) begin : g_bad_width
         $error("ttw_top: tap table serves only 21-bit base and 15-bit slow counters");
      end
   endgenerate

   // Tap decode shared by both counters and the watchdog
   function automatic logic tap_hit(input logic [20:0] cnt, input logic [4:0] tap);
      logic hit;
      hit = 1'b1;
      for (int i = 0; i < 21; i++) begin
         if (i <= int'(tap) && !cnt[i]) begin
            hit = 1'b0;
         end
      end
      return hit;
   endfunction

   function automatic logic [4:0] slow_tap(input logic [1:0] sel);
      logic [4:0] t;
      unique case (sel)
         2'h0: t = SLOW_TAP0;
         2'h1: t = SLOW_TAP1;
         2'h2: t = SLOW_TAP2;
         2'h3: t = SLOW_TAP3;
      endcase
      return t;
   endfunction

   function automatic logic [4:0] base_tap(input logic [1:0] sel);
      logic [4:0] t;
      unique case (sel)
         2'h0: t = BASE_TAP0;
         2'h1: t = BASE_TAP1;
         2'h2: t = BASE_TAP2;
         2'h3: t = BASE_TAP3;
      endcase
      return t;
   endfunction

   // ---------------- APB decode ----------------
   ttw_apb_req_t req;
   assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I,
                  addr: PADDR_I, wdata: PWDATA_I, strb0: PSTRB_I[0]};

   wire        access     = req.sel && req.enable;
   wire        idx_ok     = (req.addr[1:0] == 2'h0) && (req.addr[11:10] == 2'h0);
   wire [7:0]  idx        = req.addr[9:2];
   wire        hit_dog    = idx_ok && (idx == DOG_CTRL_IDX);
   wire        hit_base   = idx_ok && (idx == BASE_CTRL_IDX);
   wire        hit_slow   = idx_ok && (idx == SLOW_CTRL_IDX);
   wire        mapped     = hit_dog || hit_base || hit_slow;
   wire        wr_lane    = access && req.write && req.strb0;
   wire        wr_dog     = wr_lane && hit_dog;
   wire        wr_base    = wr_lane && hit_base;
   wire        wr_slow    = wr_lane && hit_slow;
   wire [7:0]  wbyte      = req.wdata[7:0];

   // Zero-latency slave: every access completes in its first access cycle
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = access && !mapped;

   // ---------------- Slow prescaler ----------------
   logic [14:0] slow_cnt;
   ttw_intv_t   slow;
   wire  [20:0] slow_cnt_x  = {6'h00, slow_cnt};
   wire         slow_clr    = wr_slow && !wbyte[CLR_BIT];                       // [RQ6]
   wire         slow_evt    = SUB_TICK_I && tap_hit(slow_cnt_x, slow_tap(slow.sel)); // [RQ5]
   wire         slow_dogtk  = SUB_TICK_I && tap_hit(slow_cnt_x, DOG_SLOW_TAP);
   wire         slow_fclr   = wr_slow && !wbyte[FLAG_BIT];                      // [RQ2]
   wire [14:0]  next_slow_cnt = slow_clr   ? 15'h0000 :
                                SUB_TICK_I ? slow_cnt + 15'h0001 : slow_cnt;    // [RQ1]
   // A new interval beats a same-cycle clear so no event is lost
   wire         next_slow_flag = slow_evt || (slow.flag && !slow_fclr);         // [RQ21]

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         slow_cnt <= 15'h0000;
         slow     <= '0;                                                         // [RQ12]
      end else begin
         slow_cnt  <= next_slow_cnt;
         slow.flag <= next_slow_flag;
         if (wr_slow) begin
            slow.irq_en <= wbyte[IE_BIT];
            slow.sel    <= wbyte[SEL_HI:SEL_LO];
         end
      end
   end

   assign SLOW_IRQ_O = slow.flag && slow.irq_en;                                 // [RQ3]

   // ---------------- Base timer ----------------
   logic        half;
   logic [20:0] base_cnt;
   ttw_intv_t   base;
   // Halving the main clock: count only on every second running cycle
   wire         base_step  = MAIN_CLK_RUN_I && half;                             // [RQ8]
   wire         base_clr   = wr_base && !wbyte[CLR_BIT];                         // [RQ11]
   wire         base_evt   = base_step && tap_hit(base_cnt, base_tap(base.sel)); // [RQ10]
   wire         base_dogtk = base_step && tap_hit(base_cnt, DOG_BASE_TAP);
   wire         base_fclr  = wr_base && !wbyte[FLAG_BIT];                        // [RQ9]
   wire [20:0]  next_base_cnt = base_clr  ? 21'h000000 :
                                base_step ? base_cnt + 21'h000001 : base_cnt;    // [RQ8]
   wire         next_base_flag = base_evt || (base.flag && !base_fclr);          // [RQ21]

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         half     <= 1'b0;
         base_cnt <= 21'h000000;
         base     <= '0;                                                         // [RQ12]
      end else begin
         half      <= MAIN_CLK_RUN_I ? !half : half;
         base_cnt  <= next_base_cnt;
         base.flag <= next_base_flag;
         if (wr_base) begin
            base.irq_en <= wbyte[IE_BIT];
            base.sel    <= wbyte[SEL_HI:SEL_LO];
         end
      end
   end

   assign BASE_IRQ_O = base.flag && base.irq_en;                                 // [RQ9]

   // ---------------- Watchdog ----------------
   ttw_dog_state_t dog_state;
   logic           dog_src;
   logic [1:0]     dog_cnt;
   logic           dog_fire;

   wire key_ok      = wbyte[KEY_HI:0] == DOG_KEY;
   wire dog_start   = wr_dog && (dog_state == DOG_FRESH) && key_ok;              // [RQ15]
   wire dog_kick    = wr_dog && (dog_state == DOG_RUNNING) && key_ok;            // [RQ16]
   // Source bit is honoured only while the watchdog is not yet running
   wire src_wr      = wr_dog && (dog_state != DOG_RUNNING);
   wire dog_tick    = dog_src ? slow_dogtk : base_dogtk;                         // [RQ13]
   wire dog_restart = dog_kick || STANDBY_I;                                     // [RQ18]
   wire dog_expire  = (dog_state == DOG_RUNNING) && !dog_restart && dog_tick &&
                      (dog_cnt == DOG_EXPIRE_CNT - 2'h1);                        // [RQ20]

   ttw_dog_state_t next_dog_state;
   always_comb begin
      next_dog_state = dog_state;
      unique case (dog_state)
         DOG_FRESH: begin
            if (wr_dog) begin
               next_dog_state = key_ok ? DOG_RUNNING : DOG_BARRED;               // [RQ15]
            end
         end
         DOG_BARRED: begin
            next_dog_state = DOG_BARRED;
         end
         DOG_RUNNING: begin
            next_dog_state = DOG_RUNNING;                                        // [RQ17]
         end
      endcase
   end

   wire [1:0] next_dog_cnt = (dog_start || dog_restart)          ? 2'h0 :
                             (dog_state == DOG_RUNNING && dog_tick) ? dog_cnt + 2'h1 :
                             dog_cnt;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         dog_state <= DOG_FRESH;
         dog_src   <= 1'b0;
         dog_cnt   <= 2'h0;
         dog_fire  <= 1'b0;
      end else begin
         dog_state <= next_dog_state;
         dog_cnt   <= next_dog_cnt;
         if (src_wr) begin
            dog_src <= wbyte[DOG_SRC_BIT];                                       // [RQ14]
         end
         // Held until the chip reset it requests comes back on RSTN_I
         dog_fire  <= dog_fire || dog_expire;                                    // [RQ19]
      end
   end

   assign WDOG_RST_O = dog_fire;

   // ---------------- Read data ----------------
   wire       rmw = RMW_READ_I;
   wire [7:0] slow_rd = {slow.flag || rmw, slow.irq_en, 3'h0, slow.sel, 1'b1};  // [RQ4] [RQ7]
   wire [7:0] base_rd = {base.flag || rmw, base.irq_en, 3'h0, base.sel, 1'b1};  // [RQ4] [RQ7]
   wire [7:0] dog_rd  = {dog_src, 3'h0, DOG_KEY_READ};                          // [RQ17]
   wire [7:0] rd_byte = hit_slow ? slow_rd :
                        hit_base ? base_rd :
                        hit_dog  ? dog_rd  : 8'h00;
   wire       rd_take = req.sel && !req.enable && !req.write;

   // Captured in the setup cycle so the flop presents data for the access edge
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PRDATA_O <= 32'h00000000;
      end else if (rd_take) begin
         PRDATA_O <= {24'h000000, rd_byte};
      end
   end

endmodule // ttw_top

// ---- tb/test_ttw_top.sv ----
// Self-checking bench for the tick timers and watchdog block
`timescale 1ns/1ns
module test_ttw_top import ttw_pkg::*;;
   localparam logic [11:0] A_DOG  = {2'h0, DOG_CTRL_IDX, 2'h0};
   localparam logic [11:0] A_BASE = {2'h0, BASE_CTRL_IDX, 2'h0};
   localparam logic [11:0] A_SLOW = {2'h0, SLOW_CTRL_IDX, 2'h0};
   logic        CLK_I = 1'b0, RSTN_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0;
   logic        PWRITE_I = 1'b0, SUB_TICK_I = 1'b0, MAIN_CLK_RUN_I = 1'b1;
   logic        RMW_READ_I = 1'b0, STANDBY_I = 1'b0;
   logic [11:0] PADDR_I = 12'h000;
   logic [31:0] PWDATA_I = 32'h0;
   logic [3:0]  PSTRB_I = 4'hF;
   wire  [31:0] PRDATA_O;
   wire         PREADY_O, PSLVERR_O, SLOW_IRQ_O, BASE_IRQ_O, WDOG_RST_O;
   wire  [2:0]  outs = {WDOG_RST_O, BASE_IRQ_O, SLOW_IRQ_O};
   logic [7:0]  cap_d;
   logic        cap_e;
   int          mismatches = 0, num_checks = 0, cyc = 0;

   ttw_top dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
      .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
      .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
      .SUB_TICK_I(SUB_TICK_I), .MAIN_CLK_RUN_I(MAIN_CLK_RUN_I), .RMW_READ_I(RMW_READ_I),
      .STANDBY_I(STANDBY_I), .SLOW_IRQ_O(SLOW_IRQ_O), .BASE_IRQ_O(BASE_IRQ_O),
      .WDOG_RST_O(WDOG_RST_O));

   initial begin
      forever #50 CLK_I = ~CLK_I;
   end

   // Read data is captured at the completing edge itself, free of scheduling races
   always @(posedge CLK_I) begin
      if (PSEL_I && PENABLE_I && PREADY_O) begin
         cap_d <= PRDATA_O[7:0];
         cap_e <= PSLVERR_O;
      end
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      PSEL_I   <= 1'b1;
      PWRITE_I <= wr;
      PADDR_I  <= a;
      PWDATA_I <= {24'h0, d};
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      do @(posedge CLK_I); while (PREADY_O !== 1'b1);
      PSEL_I    <= 1'b0;
      PENABLE_I <= 1'b0;
      @(posedge CLK_I);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk8(cap_d & m, e);
   endtask

   // Outputs are judged mid-cycle, then stimulus resumes on a rising edge
   task automatic sample(input int b, input logic e);
      @(negedge CLK_I);
      chk1(outs[b], e);
      @(posedge CLK_I);
   endtask

   task automatic run(input int n);
      SUB_TICK_I <= 1'b1;
      repeat (n) @(posedge CLK_I);
      SUB_TICK_I <= 1'b0;
      @(posedge CLK_I);
   endtask

   task automatic pulse_chk(input int n, input int b);
      run(n - 1);
      sample(b, 1'b0);
      run(1);
      @(posedge CLK_I);
      sample(b, 1'b1);
   endtask

   initial begin
      repeat (5) @(posedge CLK_I);
      RSTN_I <= 1'b1;
      @(posedge CLK_I);
      rdchk(A_SLOW, 8'hC7, 8'h01);
      rdchk(A_BASE, 8'hC7, 8'h01);
      rdchk(A_DOG, 8'hFF, 8'h0F);
      apb(1'b0, 12'h030, 8'h00);
      chk1(cap_e, 1'b1);
      chk8(cap_d, 8'h00);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, A_SLOW, {5'h00, c[1:0], 1'b1});
         rdchk(A_SLOW, 8'hC7, {5'h00, c[1:0], 1'b1});
         apb(1'b1, A_BASE, {5'h00, c[1:0], 1'b1});
         rdchk(A_BASE, 8'hC7, {5'h00, c[1:0], 1'b1});
      end
      apb(1'b1, A_SLOW, 8'h40);
      pulse_chk(1024, 0);
      rdchk(A_SLOW, 8'h80, 8'h80);
      apb(1'b1, A_SLOW, 8'h42);
      pulse_chk(8192, 0);
      // Base timer with a frozen stretch: the period must stretch by the same amount
      apb(1'b1, A_BASE, 8'h40);
      repeat (4000) @(posedge CLK_I);
      MAIN_CLK_RUN_I <= 1'b0;
      repeat (200) @(posedge CLK_I);
      MAIN_CLK_RUN_I <= 1'b1;
      repeat (4185) @(posedge CLK_I);
      sample(1, 1'b0);
      repeat (12) @(posedge CLK_I);
      sample(1, 1'b1);
      RMW_READ_I <= 1'b1;
      rdchk(A_BASE, 8'hC7, 8'hC1);
      RMW_READ_I <= 1'b0;
      apb(1'b1, A_BASE, 8'h40);
      sample(1, 1'b0);
      rdchk(A_BASE, 8'hC7, 8'h41);
      apb(1'b1, A_SLOW, 8'h44);
      // Source chosen once, at start; the later key writes carry source bit 0 and must leave it unchanged
      apb(1'b1, A_DOG, 8'h85);
      rdchk(A_DOG, 8'hFF, 8'h8F);
      pulse_chk(16384, 0);
      sample(2, 1'b0);
      // One tick is already counted: without the standby clear the next tick expires
      STANDBY_I <= 1'b1;
      @(posedge CLK_I);
      STANDBY_I <= 1'b0;
      @(posedge CLK_I);
      run(16384);
      sample(2, 1'b0);
      apb(1'b1, A_DOG, 8'h05);
      run(16384);
      sample(2, 1'b0);
      apb(1'b1, A_DOG, 8'h0A);
      pulse_chk(16384, 2);
      finish_test();
   end
endmodule // test_ttw_top

// ---- tb/ttw_top_checker.sv ----
// Port assertions for the tick timers and watchdog block
`timescale 1ns/1ns
module ttw_top_checker (
   input wire logic        CLK_I,
   input wire logic        RSTN_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0]  PSTRB_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PSLVERR_O,
   input wire logic        RMW_READ_I,
   input wire logic        SLOW_IRQ_O,
   input wire logic        BASE_IRQ_O,
   input wire logic        WDOG_RST_O
);
   wire acc     = PSEL_I && PENABLE_I;
   wire at_dog  = PADDR_I == 12'h024;
   wire at_base = PADDR_I == 12'h028;
   wire at_slow = PADDR_I == 12'h02C;
   wire rd      = acc && !PWRITE_I;
   wire wr      = acc && PWRITE_I && PSTRB_I[0];
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   a_err_unmapped: assert property (acc && !(at_dog || at_base || at_slow) |-> PSLVERR_O)
      else $error("unmapped access without error");
   a_key_read: assert property (rd && at_dog |-> PRDATA_O[3:0] == 4'hF)
      else $error("key bits not read as ones");
   a_clear_read: assert property (rd && (at_base || at_slow) |-> PRDATA_O[0])
      else $error("clear bit not read as one");
   a_rmw_flag: assert property (rd && RMW_READ_I && (at_base || at_slow) |-> PRDATA_O[7])
      else $error("flag not one on modify read");
   a_slow_gate: assert property (wr && at_slow && !PWDATA_I[6] |=> !SLOW_IRQ_O)
      else $error("slow request without enable");
   a_base_gate: assert property (wr && at_base && !PWDATA_I[6] |=> !BASE_IRQ_O)
      else $error("base request without enable");
   a_slow_hold: assert property (SLOW_IRQ_O && !(wr && at_slow) |=> SLOW_IRQ_O)
      else $error("slow request dropped unasked");
   a_base_hold: assert property (BASE_IRQ_O && !(wr && at_base) |=> BASE_IRQ_O)
      else $error("base request dropped unasked");
   a_dog_sticky: assert property ($rose(WDOG_RST_O) |=> WDOG_RST_O [*8])
      else $error("watchdog reset released");
endmodule // ttw_top_checker

bind ttw_top ttw_top_checker u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .RMW_READ_I(RMW_READ_I),
   .SLOW_IRQ_O(SLOW_IRQ_O), .BASE_IRQ_O(BASE_IRQ_O), .WDOG_RST_O(WDOG_RST_O));
